// [dv/rsc_core_model.sv]
// far-side model: core, stack, data ram and watchdog feed held by the controller
`default_nettype none

module rsc_core_model
    import rsc_pkg::*;
#(
    parameter logic [7:0]  SP_RST    = 8'h07,
    parameter logic [3:0]  OVF_TICKS = 4'h2
)(
    input  wire logic        clk_sys_in,
    input  wire logic        halt_in,
    input  wire logic        pc_clear_in,
    input  wire logic        sp_default_in,
    input  wire logic        ram_block_in,
    input  wire logic [15:0] fetch_addr_in,
    input  wire logic        tick_in,
    input  wire logic        starve_in,
    input  wire logic        force_ovf_in,
    output var  logic        wdt_ovf_out,
    output var  logic [15:0] pc_out,
    output var  logic [7:0]  sp_out,
    output var  logic [7:0]  ram_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0]  ticks_q = 4'h0;
    logic [15:0] pc_q    = 16'h0000;
    logic [7:0]  sp_q    = 8'h00;
    logic [7:0]  ram_q   = 8'h00;

    // core runs only while released; ram is never cleared, only written
    always_ff @(posedge clk_sys_in) begin
        pc_q <= pc_clear_in ? fetch_addr_in : pc_q + 16'h0001;
        sp_q <= sp_default_in ? SP_RST : sp_q + 8'h01;
        if (!ram_block_in) begin
            ram_q <= ram_q + 8'h01;
        end
        if (halt_in) begin
            ticks_q <= 4'h0;
        end else if (tick_in && starve_in) begin
            ticks_q <= ticks_q + 4'h1;
        end
    end

    // starved watchdog overflows after a few ticks; forced on command
    assign wdt_ovf_out = force_ovf_in || (starve_in && ticks_q == OVF_TICKS);
    assign pc_out      = pc_q;
    assign sp_out      = sp_q;
    assign ram_out     = ram_q;
endmodule

`default_nettype wire

// [dv/system_reset_state_control_test.sv]
// self-checking bench for the system reset state controller
`default_nettype none

module system_reset_state_control_test
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [10:0] drv;
        logic        halt;
        logic [7:0]  cause;
        logic        oe;
        logic        exact;
    } rsc_row_t;

    logic clk, rst_b, por, vlow, ven, pinl, starve, mto, men, cmpl, cen, ferr, sw;
    logic wdis, fovf, ovf, halt, sfrd, irqo, spd, ramb, lload, odr, pull, pdat, poe;
    logic pcc, osc, wen, wtick;
    logic [7:0]  latch, cause, sp, ram, last, ram_keep;
    logic [15:0] faddr, pc;
    int n_fail = 0;
    int total_checks = 0;
    int n;

    // drive bits: por vlow ven pinl starve mto men cmpl cen ferr sw
    rsc_row_t rows[11] = '{
        '{11'h001, 1'b1, 8'h02, 1'b1, 1'b1}, '{11'h006, 1'b1, 8'h02, 1'b1, 1'b1},
        '{11'h002, 1'b0, 8'h00, 1'b0, 1'b0}, '{11'h008, 1'b1, 8'h01, 1'b0, 1'b0},
        '{11'h010, 1'b1, 8'h08, 1'b0, 1'b0}, '{11'h060, 1'b1, 8'h04, 1'b0, 1'b1},
        '{11'h020, 1'b0, 8'h00, 1'b0, 1'b0}, '{11'h180, 1'b1, 8'h20, 1'b0, 1'b1},
        '{11'h080, 1'b0, 8'h00, 1'b0, 1'b0}, '{11'h200, 1'b1, 8'h40, 1'b0, 1'b1},
        '{11'h400, 1'b1, 8'h10, 1'b0, 1'b1}};

    rsc_reset_ctrl dut_u (
        .clk_sys_in(clk), .rst_b_in(rst_b), .por_req_in(por), .vdd_low_in(vlow),
        // pin reads low while pinl is set or the block pulls it, pull-up level otherwise
        .vdd_mon_en_in(ven), .rst_pin_in(~pinl & ~(poe & ~pdat)), .wdt_ovf_in(ovf),
        .wdt_disable_in(wdis), .mcd_timeout_in(mto), .mcd_en_in(men),
        .cmp_out_in(~cmpl), .cmp_rst_en_in(cen),
        .flash_err_in(ferr), .sw_reset_wr_in(sw), .core_halt_out(halt),
        .sfr_default_out(sfrd), .irq_timer_off_out(irqo), .sp_default_out(spd),
        .ram_wr_block_out(ramb), .port_latch_out(latch), .port_latch_load_out(lload),
        .port_open_drain_out(odr), .weak_pullup_en_out(pull), .rst_pin_out(pdat),
        .rst_pin_oe_out(poe), .pc_clear_out(pcc), .fetch_addr_out(faddr),
        .clk_sel_int_osc_out(osc), .wdt_en_out(wen), .wdt_tick_out(wtick),
        .reset_cause_register_out(cause));

    rsc_core_model far_u (
        .clk_sys_in(clk), .halt_in(halt), .pc_clear_in(pcc), .sp_default_in(spd),
        .ram_block_in(ramb), .fetch_addr_in(faddr), .tick_in(wtick), .starve_in(starve),
        .force_ovf_in(fovf), .wdt_ovf_out(ovf), .pc_out(pc), .sp_out(sp), .ram_out(ram));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            #10;
        end
    endtask

    task automatic drive(input logic [10:0] v);
        {sw, ferr, cen, cmpl, men, mto, starve, pinl, ven, vlow, por} = v;
    endtask

    // bounded wait for the halt level; k counts edges waited
    task automatic wait_halt(input logic lvl, input int max, output int k);
        k = 0;
        while (halt !== lvl && k < max) begin
            tick(1);
            k++;
        end
    endtask

    task automatic check_group(input logic [8:0] exp);
        check({halt, sfrd, irqo, spd, ramb, lload, odr, pcc, osc}, exp, "held group");
    endtask

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #500000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        wdis = 1'b0;
        fovf = 1'b0;
        drive(11'h000);
        repeat (6) @(posedge clk);
        #10;
        check(poe, 1'b1, "pin drive in reset");
        check({pull, pdat, latch, faddr}, {2'b10, 8'hff, 16'h0000}, "constants");
        rst_b = 1'b1;
        wait_halt(1'b0, 40, n);
        last = 8'h02;
        check(cause, last, "cause after power up");
        // table: each source alone, gated sources refused
        foreach (rows[i]) begin
            drive(rows[i].drv);
            wait_halt(1'b1, rows[i].halt ? 60 : 8, n);
            check(halt, rows[i].halt, "entry");
            if (rows[i].halt) begin
                last = rows[i].cause;
                check_group(9'h1ff);
                check(poe, rows[i].oe, "pin drive");
            end
            check(cause, last, "cause");
            drive(11'h000);
            wait_halt(1'b0, 60, n);
            if (rows[i].exact) check(n, 17, "hold length");
            if (rows[i].halt) begin
                check_group(9'h000);
                check({pc, sp}, {16'h0000, 8'h07}, "restart state");
            end
            tick(3);
        end
        // new request during hold restarts hold and ors its flag
        drive(11'h200);
        tick(2);
        drive(11'h000);
        tick(5);
        drive(11'h060);
        tick(1);
        drive(11'h000);
        wait_halt(1'b0, 60, n);
        check(n, 17, "restarted hold");
        check(cause, 8'h44, "or of flags");
        // watchdog tick period and enable after release
        check(wen, 1'b1, "watchdog on");
        n = 0;
        while (wtick !== 1'b1 && n < 30) begin
            tick(1);
            n++;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (wtick !== 1'b1 && n < 30);
        check(n, 12, "tick period");
        // disabled watchdog overflow is refused; software reset re-enables
        wdis = 1'b1;
        tick(1);
        wdis = 1'b0;
        tick(1);
        check(wen, 1'b0, "watchdog off");
        fovf = 1'b1;
        tick(8);
        check(halt, 1'b0, "overflow refused");
        fovf = 1'b0;
        drive(11'h400);
        tick(1);
        drive(11'h000);
        check({halt, cause}, {1'b1, 8'h10}, "software reset");
        wait_halt(1'b0, 60, n);
        check(wen, 1'b1, "watchdog back on");
        // mid-run reset keeps ram
        tick(4);
        rst_b = 1'b0;
        tick(1);
        ram_keep = ram;
        tick(3);
        check({halt, poe, wen, cause}, {3'b111, 8'h02}, "mid-run reset");
        rst_b = 1'b1;
        wait_halt(1'b0, 40, n);
        check(ram, ram_keep, "ram kept");
        conclude();
    end
endmodule

`default_nettype wire

// [src/rsc_pin_sync.sv]
// three-stage synchroniser for the external reset pin with agreement filter
`default_nettype none

module rsc_pin_sync
    import rsc_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic pin_in,
    output var  logic pin_low_out
);

    logic [SYNC_STAGES-1:0] sync_q;
    logic [SYNC_STAGES-1:0] sync_d;
    logic                   low_q;
    logic                   low_d;

    // ------------------------------------------------------------
    // next values: shift chain, accept when stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        sync_d = {sync_q[SYNC_STAGES-2:0], pin_in};
        low_d  = low_q;
        if (sync_q[1] == sync_q[2]) begin
            low_d = ~sync_q[2]; // pin is active low
        end
    end

    // ------------------------------------------------------------
    // registers, idle pin level is high
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            sync_q <= '1;
            low_q  <= 1'b0;
        end else begin
            sync_q <= sync_d;
            low_q  <= low_d;
        end
    end

    assign pin_low_out = low_q;

endmodule

`default_nettype wire

// [src/rsc_pkg.sv]
// constants and types shared by the system reset state controller
`default_nettype none

package rsc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned HOLD_NS       = 1600; // settle time after release
    localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W        = 5;
    localparam logic [HOLD_W-1:0] HOLD_LAST = 5'(HOLD_CYC - 1);

    // ------------------------------------------------------------
    // watchdog prescaler
    // ------------------------------------------------------------
    localparam int unsigned WDT_DIV      = 12;
    localparam int unsigned WDT_CNT_W    = 4;
    localparam logic [WDT_CNT_W-1:0] WDT_CNT_LAST = 4'(WDT_DIV - 1);

    // ------------------------------------------------------------
    // reset cause register field positions
    // ------------------------------------------------------------
    localparam int unsigned CAUSE_W     = 8;
    localparam int unsigned REQ_W       = 7;
    localparam int unsigned B_PIN       = 0;
    localparam int unsigned B_POR       = 1;
    localparam int unsigned B_MCD       = 2;
    localparam int unsigned B_WDT       = 3;
    localparam int unsigned B_SW        = 4;
    localparam int unsigned B_CMP       = 5;
    localparam int unsigned B_FLASH     = 6;
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h02; // power-on flag only

    // ------------------------------------------------------------
    // reset values driven towards core and ports
    // ------------------------------------------------------------
    localparam logic [7:0]  PORT_LATCH_RST = 8'hff;
    localparam logic [15:0] RESET_VECTOR   = 16'h0000;

    // pin synchroniser depth
    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESET,
        ST_HOLD
    } rsc_state_t;

endpackage

`default_nettype wire

// [src/rsc_reset_ctrl.sv]
// system reset state controller: merges sources, sequences entry and exit
`default_nettype none

module rsc_reset_ctrl
    import rsc_pkg::*;
(
    input  wire logic                clk_sys_in,
    input  wire logic                rst_b_in,
    input  wire logic                por_req_in,
    input  wire logic                vdd_low_in,
    input  wire logic                vdd_mon_en_in,
    input  wire logic                rst_pin_in,
    input  wire logic                wdt_ovf_in,
    input  wire logic                wdt_disable_in,
    input  wire logic                mcd_timeout_in,
    input  wire logic                mcd_en_in,
    input  wire logic                cmp_out_in,
    input  wire logic                cmp_rst_en_in,
    input  wire logic                flash_err_in,
    input  wire logic                sw_reset_wr_in,
    output var  logic                core_halt_out,
    output var  logic                sfr_default_out,
    output var  logic                irq_timer_off_out,
    output var  logic                sp_default_out,
    output var  logic                ram_wr_block_out,
    output var  logic [7:0]          port_latch_out,
    output var  logic                port_latch_load_out,
    output var  logic                port_open_drain_out,
    output var  logic                weak_pullup_en_out,
    output var  logic                rst_pin_out,
    output var  logic                rst_pin_oe_out,
    output var  logic                pc_clear_out,
    output var  logic [15:0]         fetch_addr_out,
    output var  logic                clk_sel_int_osc_out,
    output var  logic                wdt_en_out,
    output var  logic                wdt_tick_out,
    output var  logic [CAUSE_W-1:0]  reset_cause_register_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    rsc_state_t          state_q;
    rsc_state_t          state_d;
    logic [HOLD_W-1:0]   hold_q;
    logic [HOLD_W-1:0]   hold_d;
    logic [CAUSE_W-1:0]  cause_q;
    logic [CAUSE_W-1:0]  cause_d;
    logic [REQ_W-1:0]    req;
    logic                any_req;
    logic                pin_low;
    logic                wdt_en_q;
    logic                wdt_en_d;
    logic                wdt_run;
    logic                in_rst_q;
    logic                in_rst_d;
    logic                drive_q;
    logic                drive_d;
    logic                pc_clr_q;
    logic                pc_clr_d;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    rsc_pin_sync u_pin_sync (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .pin_in      (rst_pin_in),
        .pin_low_out (pin_low)
    );

    // prescaler only runs while the core executes
    assign wdt_run = wdt_en_q && (state_q == ST_RUN);

    rsc_wdt_div u_wdt_div (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .run_in     (wdt_run),
        .tick_out   (wdt_tick_out)
    );

    // ------------------------------------------------------------
    // reset request collection
    // ------------------------------------------------------------
    // own pin drive echoes back; ignore pin while holding after release
    always_comb begin
        req          = '0;
        req[B_PIN]   = pin_low && (state_q != ST_HOLD);
        req[B_POR]   = por_req_in || (vdd_mon_en_in && vdd_low_in);
        req[B_MCD]   = mcd_en_in && mcd_timeout_in;
        req[B_WDT]   = wdt_ovf_in && wdt_en_q;
        req[B_SW]    = sw_reset_wr_in && (state_q == ST_RUN);
        req[B_CMP]   = cmp_rst_en_in && !cmp_out_in; // comparator is active low
        req[B_FLASH] = flash_err_in;
        any_req      = |req;
    end

    // ------------------------------------------------------------
    // sequencer and cause flags: next values
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        hold_d  = hold_q;
        cause_d = cause_q;
        case (state_q)
            ST_RUN: begin
                if (any_req) begin
                    state_d = ST_RESET;
                    cause_d = {1'b0, req}; // fresh record per reset
                end
            end
            ST_RESET: begin
                cause_d = cause_q | {1'b0, req};
                if (!any_req) begin
                    state_d = ST_HOLD; // all requests released
                    hold_d  = '0;
                end
            end
            ST_HOLD: begin
                if (any_req) begin
                    state_d = ST_RESET;
                    cause_d = cause_q | {1'b0, req};
                end else if (hold_q == HOLD_LAST) begin
                    state_d = ST_RUN;
                end else begin
                    hold_d = hold_q + 5'h01;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer and cause flags: registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_q <= ST_RESET;
            hold_q  <= '0;
            cause_q <= CAUSE_RST;
        end else begin
            state_q <= state_d;
            hold_q  <= hold_d;
            cause_q <= cause_d;
        end
    end

    // ------------------------------------------------------------
    // output controls: next values, aligned with the state register
    // ------------------------------------------------------------
    always_comb begin
        in_rst_d = (state_d != ST_RUN);
        drive_d  = (state_d == ST_RESET) && cause_d[B_POR];
        pc_clr_d = in_rst_d;
        wdt_en_d = wdt_en_q;
        if (in_rst_d) begin
            wdt_en_d = 1'b1;
        end else if (wdt_disable_in && (state_q == ST_RUN)) begin // only a running core disables
            wdt_en_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output controls: registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            in_rst_q <= 1'b1;
            drive_q  <= 1'b1;
            pc_clr_q <= 1'b1;
            wdt_en_q <= 1'b1;
        end else begin
            in_rst_q <= in_rst_d;
            drive_q  <= drive_d;
            pc_clr_q <= pc_clr_d;
            wdt_en_q <= wdt_en_d;
        end
    end

    // ------------------------------------------------------------
    // output wiring, every one from a flip-flop or a constant
    // ------------------------------------------------------------
    assign core_halt_out            = in_rst_q;
    assign sfr_default_out          = in_rst_q;
    assign irq_timer_off_out        = in_rst_q;
    assign sp_default_out           = in_rst_q;
    assign ram_wr_block_out         = in_rst_q; // ram left untouched
    assign port_latch_out           = PORT_LATCH_RST;
    assign port_latch_load_out      = in_rst_q;
    assign port_open_drain_out      = in_rst_q;
    assign weak_pullup_en_out       = 1'b1;
    assign rst_pin_out              = 1'b0; // only ever pulls low
    assign rst_pin_oe_out           = drive_q;
    assign pc_clear_out             = pc_clr_q;
    assign fetch_addr_out           = RESET_VECTOR;
    assign clk_sel_int_osc_out      = in_rst_q;
    assign wdt_en_out               = wdt_en_q;
    assign reset_cause_register_out = cause_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_run_req;
        !core_halt_out && any_req;
    endsequence

    sequence s_release;
        $fell(core_halt_out);
    endsequence

    property p_halt_on_req;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_run_req |=> core_halt_out ##1 core_halt_out;
    endproperty
    a_halt_on_req: assert property (p_halt_on_req)
        else $error("core not halted after reset request");

    property p_defaults;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        core_halt_out |-> sfr_default_out && irq_timer_off_out && sp_default_out;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("defaults not forced during reset");

    property p_ports;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        core_halt_out |-> port_open_drain_out && port_latch_load_out
                          && (port_latch_out == 8'hff);
    endproperty
    a_ports: assert property (p_ports)
        else $error("ports not forced to ones open-drain");

    property p_ram_kept;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(core_halt_out) |-> ram_wr_block_out ##1 ram_wr_block_out;
    endproperty
    a_ram_kept: assert property (p_ram_kept)
        else $error("ram writes not blocked in reset");

    property p_pullup;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_release |-> weak_pullup_en_out && $past(weak_pullup_en_out);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("weak pullups off around release");

    property p_pin_drive;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        rst_pin_oe_out |-> core_halt_out && reset_cause_register_out[B_POR]
                           && !rst_pin_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("reset pin driven without supply cause");

    property p_exit;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_release |-> $past(pc_clear_out) && $past(clk_sel_int_osc_out)
                      && wdt_en_out && (fetch_addr_out == 16'h0000);
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit state not prepared on release");

    property p_wdt_div;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wdt_tick_out && wdt_run) ##1 wdt_run [*8] ##1 wdt_run [*3]
        |=> wdt_tick_out;
    endproperty
    a_wdt_div: assert property (p_wdt_div)
        else $error("watchdog tick spacing not twelve");

    property p_sw_flag;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!core_halt_out && sw_reset_wr_in) |=> reset_cause_register_out[B_SW];
    endproperty
    a_sw_flag: assert property (p_sw_flag)
        else $error("software reset flag not set");

    property p_wdt_flag;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!core_halt_out && wdt_ovf_in && wdt_en_out)
        |=> reset_cause_register_out[B_WDT] ##1 reset_cause_register_out[B_WDT];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag)
        else $error("watchdog cause flag not recorded");

    property p_exit_clean;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_release |-> !$past(any_req) && ($past(state_q) == ST_HOLD);
    endproperty
    a_exit_clean: assert property (p_exit_clean)
        else $error("reset left with request pending");

    property p_por_drive;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        por_req_in |=> rst_pin_oe_out;
    endproperty
    a_por_drive: assert property (p_por_drive)
        else $error("reset pin not driven during power reset");

    property p_wdt_first;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_release ##1 wdt_run [*8] ##1 wdt_run [*3] |=> wdt_tick_out;
    endproperty
    a_wdt_first: assert property (p_wdt_first)
        else $error("first watchdog tick not twelve clocks after release");

endmodule

`default_nettype wire

// [src/rsc_wdt_div.sv]
// watchdog clock prescaler: one tick every twelve system clocks
`default_nettype none

module rsc_wdt_div
    import rsc_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic run_in,
    output var  logic tick_out
);

    logic [WDT_CNT_W-1:0] cnt_q;
    logic [WDT_CNT_W-1:0] cnt_d;
    logic                 tick_q;
    logic                 tick_d;

    // ------------------------------------------------------------
    // next values: restart from zero whenever stopped
    // ------------------------------------------------------------
    always_comb begin
        cnt_d  = '0;
        tick_d = 1'b0;
        if (run_in) begin
            if (cnt_q == WDT_CNT_LAST) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule

`default_nettype wire
